//--- hw/twowire_master_receiver.v
// Two-wire serial master receiver with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
`include "twowire_master_receiver_regs.vh"

// Contract
// - Start request waits for free bus, sends START
// - After START set done flag, status 0x08
// - Read address enters receive, write enters transmit
// - After address acknowledge report 0x38, 0x40, 0x48
// - Received byte readable when done flag set
// - Stop request write sends STOP, ends transfer
// - Start request write gives repeated START, 0x10
// - From 0x10 address direction picks the mode
// - Lost arbitration reports 0x38, releases or restarts
// - In 0x40/0x50 receive byte, ACK per enable
// - Report 0x50 after ACK, 0x58 after NACK
// - In 0x48/0x58 restart, stop, or stop-then-start
// - Stop request self-clears after STOP sent
// - Works only enabled; writing done one clears it
// - Repeated START keeps bus ownership
module twowire_master_receiver (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write channels
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output wire [1:0]  bresp,
	output wire        bvalid,
	input  wire        bready,
	// AXI4-Lite read channels
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output wire [31:0] rdata,
	output wire [1:0]  rresp,
	output wire        rvalid,
	input  wire        rready,
	// Serial clock line
	input  wire        scl_i,
	output wire        scl_o,
	output wire        scl_oe,
	// Serial data line
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe,
	// Interrupt
	output wire        irq
);

	localparam [2:0] S_IDLE   = 3'd0;
	localparam [2:0] S_WAIT   = 3'd1;
	localparam [2:0] S_START  = 3'd2;
	localparam [2:0] S_XFER   = 3'd3;
	localparam [2:0] S_HOLD   = 3'd4;
	localparam [2:0] S_RSTART = 3'd5;
	localparam [2:0] S_STOP   = 3'd6;
	localparam [31:0] QTR_LAST = `QUARTER_CYC - 1;

	// Register bus state
	reg        awready_q;
	reg        wready_q;
	reg        bvalid_q;
	reg [1:0]  bresp_q;
	reg        arready_q;
	reg        rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0]  rresp_q;
	reg        aw_got_q;
	reg        w_got_q;
	reg [7:0]  waddr_q;
	reg [7:0]  wbyte_q;
	reg        wlane_q;
	// Software visible state
	reg        done_q;
	reg        ack_en_q;
	reg        sta_q;
	reg        sto_q;
	reg        wc_q;
	reg        en_q;
	reg        ie_q;
	reg [7:0]  status_q;
	reg [7:0]  shift_q;
	reg [1:0]  irq_stat_q;
	reg [1:0]  irq_mask_q;
	reg        irq_q;
	// Engine
	reg [2:0]  st_q;
	reg [1:0]  ph_q;
	reg [3:0]  bit_q;
	reg        addr_ph_q;
	reg        mode_tx_q;
	reg        ack_rx_q;
	reg        ack_tx_q;
	reg        scl_oe_q;
	reg        sda_oe_q;
	reg        pin_lo_q;
	reg [9:0]  div_q;
	reg        tick_q;
	// Line synchronisers and bus monitor
	reg        scl_m_q;
	reg        scl_s_q;
	reg        sda_m_q;
	reg        sda_s_q;
	reg        sda_p_q;
	reg        busy_q;

	wire aw_take = awvalid & awready_q;
	wire w_take  = wvalid & wready_q;
	wire ar_take = arvalid & arready_q;
	wire do_wr   = aw_got_q & w_got_q & ~bvalid_q;
	wire tx_now  = addr_ph_q | mode_tx_q;
	wire out_bit = drive_bit(tx_now, bit_q, shift_q[7], ack_en_q);

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFF_CONTROL) || (a == `OFF_STATUS) ||
				(a == `OFF_DATA) || (a == `OFF_IRQ_STATUS) ||
				(a == `OFF_IRQ_MASK);
		end
	endfunction

	// Level the device puts on the data line for a bit slot; one is release
	function drive_bit;
		input       tx;
		input [3:0] n;
		input       msb;
		input       ack_en;
		begin
			if (n == 4'd8)
				drive_bit = tx ? 1'b1 : ~ack_en;
			else
				drive_bit = tx ? msb : 1'b1;
		end
	endfunction

	function [7:0] byte_status;
		input addr;
		input tx;
		input rw;
		input ack_rx;
		input ack_tx;
		begin
			if (addr && rw)
				byte_status = ack_rx ? `ST_AR_ACK : `ST_AR_NACK;
			else if (addr)
				byte_status = ack_rx ? `ST_AW_ACK : `ST_AW_NACK;
			else if (tx)
				byte_status = ack_rx ? `ST_DW_ACK : `ST_DW_NACK;
			else
				byte_status = ack_tx ? `ST_DR_ACK : `ST_DR_NACK;
		end
	endfunction

	function [31:0] read_mux;
		input [7:0] a;
		begin
			case (a)
			`OFF_CONTROL:
				read_mux = {24'h000000, done_q, ack_en_q, sta_q, sto_q,
					wc_q, en_q, 1'b0, ie_q};
			`OFF_STATUS:     read_mux = {24'h000000, status_q};
			`OFF_DATA:       read_mux = {24'h000000, shift_q};
			`OFF_IRQ_STATUS: read_mux = {30'h00000000, irq_stat_q};
			`OFF_IRQ_MASK:   read_mux = {30'h00000000, irq_mask_q};
			default:         read_mux = 32'h00000000;
			endcase
		end
	endfunction

	// Line synchronisers; the first stage is never looked at, and a third data stage feeds the bus monitor
	always @(posedge aclk) begin
		if (!aresetn) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			busy_q  <= 1'b0;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			if (scl_s_q && sda_p_q && !sda_s_q)
				busy_q <= 1'b1;
			else if (scl_s_q && !sda_p_q && sda_s_q)
				busy_q <= 1'b0;
		end
	end

	// Quarter-bit enable
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_q  <= 10'h000;
			tick_q <= 1'b0;
		end else if (div_q == QTR_LAST[9:0]) begin
			div_q  <= 10'h000;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 10'h001;
			tick_q <= 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_q  <= 1'b0;
			wready_q   <= 1'b0;
			bvalid_q   <= 1'b0;
			bresp_q    <= `RESP_OKAY;
			arready_q  <= 1'b0;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h00000000;
			rresp_q    <= `RESP_OKAY;
			aw_got_q   <= 1'b0;
			w_got_q    <= 1'b0;
			waddr_q    <= 8'h00;
			wbyte_q    <= 8'h00;
			wlane_q    <= 1'b0;
			done_q     <= 1'b0;
			ack_en_q   <= 1'b0;
			sta_q      <= 1'b0;
			sto_q      <= 1'b0;
			wc_q       <= 1'b0;
			en_q       <= 1'b0;
			ie_q       <= 1'b0;
			status_q   <= `STATUS_RESET;
			shift_q    <= `DATA_RESET;
			irq_stat_q <= `IRQ_RESET;
			irq_mask_q <= `IRQ_RESET;
			irq_q      <= 1'b0;
			st_q       <= S_IDLE;
			ph_q       <= 2'd0;
			bit_q      <= 4'd0;
			addr_ph_q  <= 1'b0;
			mode_tx_q  <= 1'b0;
			ack_rx_q   <= 1'b0;
			ack_tx_q   <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
			pin_lo_q   <= 1'b0;
		end else begin
			// Address and data are taken in either order
			if (aw_take) begin
				aw_got_q <= 1'b1;
				waddr_q  <= awaddr;
			end
			if (w_take) begin
				w_got_q <= 1'b1;
				wbyte_q <= wdata[7:0];
				wlane_q <= wstrb[0];
			end
			awready_q <= ~(aw_got_q | aw_take) | do_wr;
			wready_q  <= ~(w_got_q | w_take) | do_wr;
			if (bvalid_q && bready)
				bvalid_q <= 1'b0;
			if (do_wr) begin
				aw_got_q  <= 1'b0;
				w_got_q   <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
				bvalid_q  <= 1'b1;
				bresp_q   <= mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (do_wr && wlane_q) begin
				case (waddr_q)
				`OFF_CONTROL: begin
					ack_en_q <= wbyte_q[`CTL_ACK];
					sta_q    <= wbyte_q[`CTL_STA];
					sto_q    <= wbyte_q[`CTL_STO];
					en_q     <= wbyte_q[`CTL_EN];
					ie_q     <= wbyte_q[`CTL_IE];
					if (wbyte_q[`CTL_DONE])
						done_q <= 1'b0;
				end
				`OFF_DATA: begin
					// Loading mid-transfer would corrupt the shifter
					if (done_q) begin
						shift_q <= wbyte_q;
						wc_q    <= 1'b0;
					end else begin
						wc_q <= 1'b1;
					end
				end
				`OFF_IRQ_STATUS: irq_stat_q <= irq_stat_q & ~wbyte_q[1:0];
				`OFF_IRQ_MASK:   irq_mask_q <= wbyte_q[1:0];
				default: ;
				endcase
			end
			// Read channel answers one cycle after the address
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q  <= read_mux(araddr);
				rresp_q  <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
			arready_q <= ~(ar_take | (rvalid_q & ~rready));
			irq_q     <= |(irq_stat_q & irq_mask_q);

			// Engine; hardware sets below win over software clears above
			if (!en_q) begin
				st_q     <= S_IDLE;
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (tick_q) begin
				case (st_q)
				S_IDLE: begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					if (sta_q && !done_q)
						st_q <= S_WAIT;
				end
				S_WAIT: begin
					if (!busy_q && scl_s_q && sda_s_q) begin
						st_q <= S_START;
						ph_q <= 2'd0;
					end
				end
				S_START: begin
					if (ph_q == 2'd0) begin
						sda_oe_q <= 1'b1;
						ph_q     <= 2'd1;
					end else begin
						scl_oe_q      <= 1'b1;
						st_q          <= S_HOLD;
						status_q      <= `ST_START;
						done_q        <= 1'b1;
						irq_stat_q[`IRQ_DONE] <= 1'b1;
						addr_ph_q     <= 1'b1;
					end
				end
				S_HOLD: begin
					// Clock stays low until the flag is cleared, except after lost arbitration, when it is already released
					if (!done_q) begin
						ph_q  <= 2'd0;
						bit_q <= 4'd0;
						if (status_q == `ST_ARB)
							st_q <= sta_q ? S_WAIT : S_IDLE;
						else if (sto_q)
							st_q <= S_STOP;
						else if (sta_q)
							st_q <= S_RSTART;
						else
							st_q <= S_XFER;
					end
				end
				S_XFER: begin
					case (ph_q)
					2'd0: begin
						sda_oe_q <= ~out_bit;
						if (bit_q == 4'd8)
							ack_tx_q <= ack_en_q;
						ph_q <= 2'd1;
					end
					2'd1: begin
						scl_oe_q <= 1'b0;
						ph_q     <= 2'd2;
					end
					2'd2: begin
						// Waits here while a slave stretches the clock
						if (scl_s_q) begin
							if (out_bit && !sda_s_q &&
								(tx_now ? bit_q != 4'd8 : bit_q == 4'd8)) begin
								sda_oe_q <= 1'b0;
								status_q <= `ST_ARB;
								done_q   <= 1'b1;
								irq_stat_q <= 2'b11;
								addr_ph_q <= 1'b0;
								st_q     <= S_HOLD;
							end else begin
								if (bit_q == 4'd8)
									ack_rx_q <= ~sda_s_q;
								else
									shift_q <= {shift_q[6:0], sda_s_q};
								ph_q <= 2'd3;
							end
						end
					end
					default: begin
						scl_oe_q <= 1'b1;
						ph_q     <= 2'd0;
						if (bit_q == 4'd8) begin
							// Data line kept until the next slot: moving it
							// as the clock falls breaks hold time
							status_q <= byte_status(addr_ph_q, mode_tx_q,
								shift_q[0], ack_rx_q, ack_tx_q);
							done_q   <= 1'b1;
							irq_stat_q[`IRQ_DONE] <= 1'b1;
							if (addr_ph_q)
								mode_tx_q <= ~shift_q[0];
							addr_ph_q <= 1'b0;
							st_q      <= S_HOLD;
						end else begin
							bit_q <= bit_q + 4'd1;
						end
					end
					endcase
				end
				S_RSTART: begin
					// Data released while the clock is low, so no STOP is seen and the bus stays ours
					case (ph_q)
					2'd0: begin
						sda_oe_q <= 1'b0;
						ph_q     <= 2'd1;
					end
					2'd1: begin
						scl_oe_q <= 1'b0;
						ph_q     <= 2'd2;
					end
					2'd2: begin
						if (scl_s_q) begin
							sda_oe_q <= 1'b1;
							ph_q     <= 2'd3;
						end
					end
					default: begin
						scl_oe_q  <= 1'b1;
						status_q  <= `ST_RSTART;
						done_q    <= 1'b1;
						irq_stat_q[`IRQ_DONE] <= 1'b1;
						addr_ph_q <= 1'b1;
						st_q      <= S_HOLD;
					end
					endcase
				end
				S_STOP: begin
					case (ph_q)
					2'd0: begin
						sda_oe_q <= 1'b1;
						ph_q     <= 2'd1;
					end
					2'd1: begin
						scl_oe_q <= 1'b0;
						ph_q     <= 2'd2;
					end
					2'd2: begin
						if (scl_s_q) begin
							sda_oe_q <= 1'b0;
							ph_q     <= 2'd3;
						end
					end
					default: begin
						sto_q    <= 1'b0;
						status_q <= `ST_NONE;
						st_q     <= sta_q ? S_WAIT : S_IDLE;
					end
					endcase
				end
				default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign scl_o   = pin_lo_q;
	assign scl_oe  = scl_oe_q;
	assign sda_o   = pin_lo_q;
	assign sda_oe  = sda_oe_q;
	assign irq     = irq_q;

endmodule // twowire_master_receiver

`default_nettype wire

//--- hw/twowire_master_receiver_regs.vh
// Register map, field positions, status codes and timing of the two-wire master
`ifndef TWOWIRE_MASTER_RECEIVER_REGS_VH
`define TWOWIRE_MASTER_RECEIVER_REGS_VH

// Byte offsets on the register bus
`define OFF_CONTROL     8'h00
`define OFF_STATUS      8'h04
`define OFF_DATA        8'h08
`define OFF_IRQ_STATUS  8'h0c
`define OFF_IRQ_MASK    8'h10

// Control register field positions
`define CTL_DONE        7
`define CTL_ACK         6
`define CTL_STA         5
`define CTL_STO         4
`define CTL_WC          3
`define CTL_EN          2
`define CTL_IE          0

// Interrupt status and mask bit positions
`define IRQ_DONE        0
`define IRQ_ARB         1

// Reset values
`define CONTROL_RESET   8'h00
`define STATUS_RESET    8'hf8
`define DATA_RESET      8'hff
`define IRQ_RESET       2'h0

// Bus status codes, prescaler bits always zero
`define ST_START        8'h08
`define ST_RSTART       8'h10
`define ST_AW_ACK       8'h18
`define ST_AW_NACK      8'h20
`define ST_DW_ACK       8'h28
`define ST_DW_NACK      8'h30
`define ST_ARB          8'h38
`define ST_AR_ACK       8'h40
`define ST_AR_NACK      8'h48
`define ST_DR_ACK       8'h50
`define ST_DR_NACK      8'h58
`define ST_NONE         8'hf8

// Bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// Timing: one quarter of a serial bit, rounded up to whole clocks
`define CLK_PERIOD_NS   4
`define QUARTER_NS      2500
`define QUARTER_CYC     ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verif/slave_tx_model.sv
// Behavioural slave transmitter on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module slave_tx_model #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] BYTE = 8'h1d
) (
	// Wire levels
	input wire logic scl,
	input wire logic sda,
	// Data line pull-down
	output var logic sda_pull
);
	logic       act = 1'b0;
	logic       data = 1'b0;
	logic       nack = 1'b0;
	logic [7:0] sh = 8'h00;
	int         k = 0;

	initial sda_pull = 1'b0;
	// Start or repeated start opens an address phase
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			act = 1'b1;
			data = 1'b0;
			k = 0;
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1)
			act = 1'b0;
	end
	always @(posedge scl) begin
		if (act && !data && k < 8)
			sh = {sh[6:0], sda};
		if (act && data && k == 8)
			nack = sda;
		if (act)
			k = k + 1;
	end
	// Change the pull only as the clock falls, and hold it across the high phase
	always @(negedge scl) begin
		if (act && !data && k == 8)
			sda_pull = (sh[7:1] == ADDR);
		else if (act && !data && k == 9) begin
			data = (sh == {ADDR, 1'b1});
			act = data;
			k = 0;
			sda_pull = data & ~BYTE[7];
		end else if (act && data && k < 8)
			sda_pull = ~BYTE[7 - k];
		else if (act && data && k == 8)
			sda_pull = 1'b0;
		else if (act && data && k == 9) begin
			act = ~nack;
			k = 0;
			sda_pull = act & ~BYTE[7];
		end
	end
endmodule // slave_tx_model
`default_nettype wire

//--- verif/test_twowire_master_receiver.sv
// Register-level test of the two-wire master receiver
`timescale 1ns/10ps
`default_nettype none
`include "twowire_master_receiver_regs.vh"
module test_twowire_master_receiver;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        scl_oe, sda_oe, sda_pull, irq;
	int          err_total, check_count, n;
	wire         scl = ~scl_oe;
	wire         sda = ~(sda_oe | sda_pull);

	always #2 aclk = ~aclk;

	twowire_master_receiver i_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq)
	);
	slave_tx_model i_slave (.scl(scl), .sda(sda), .sda_pull(sda_pull));

	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready is raised late on purpose so the answer must stand
	task automatic wr(input logic [7:0] a, d, input logic [1:0] er = 2'b00);
		logic bd;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bd = 1'b0;
		for (int i = 0; i < 99 && !bd; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				bd = 1'b1;
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, bresp});
			end else if (bvalid) bready <= 1'b1;
		end
		if (!bd) chk("bvalid", 32'h1, 32'h0);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff, input logic [1:0] er = 2'b00);
		logic rd;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rd = 1'b0;
		for (int i = 0; i < 99 && !rd; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rd = 1'b1;
				rready <= 1'b0;
				chk($sformatf("reg %h", a), e, rdata & m);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
			end else if (rvalid) rready <= 1'b1;
		end
		if (!rd) chk("rvalid", 32'h1, 32'h0);
	endtask

	task automatic wait_ev(input logic [7:0] st);
		int i;
		for (i = 0; i < 30000 && irq !== 1'b1; i++)
			@(posedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		rc(`OFF_STATUS, {24'h0, st});
		rc(`OFF_CONTROL, 32'h80, 32'h80);
	endtask

	task automatic complete_run;
		$display("Mismatches %0d, comparisons %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#480000;
		err_total++;
		complete_run;
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rc(`OFF_CONTROL, 32'h0);
		rc(`OFF_STATUS, 32'hf8);
		rc(`OFF_DATA, 32'hff);
		rc(`OFF_IRQ_STATUS, 32'h0);
		rc(`OFF_IRQ_MASK, 32'h0);
		rc(8'h14, 32'h0, 32'hffffffff, `RESP_SLVERR);
		wr(8'h14, 8'h01, `RESP_SLVERR);
		// Data load outside a stall is refused
		wr(`OFF_DATA, 8'h55);
		rc(`OFF_CONTROL, 32'h08, 32'h08);
		rc(`OFF_DATA, 32'hff);
		wr(`OFF_CONTROL, 8'h20);
		repeat (1400) @(posedge aclk);
		chk("sda_oe off", 32'h0, {31'h0, sda_oe});
		rc(`OFF_STATUS, 32'hf8);
		wr(`OFF_IRQ_MASK, 8'h01);
		wr(`OFF_CONTROL, 8'ha4);
		wait_ev(`ST_START);
		wr(`OFF_IRQ_MASK, 8'h00);
		rc(`OFF_IRQ_STATUS, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`OFF_IRQ_MASK, 8'h01);
		wr(`OFF_IRQ_STATUS, 8'h01);
		rc(`OFF_IRQ_STATUS, 32'h0);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(`OFF_DATA, 8'h55);
		wr(`OFF_CONTROL, 8'h84);
		wait_ev(`ST_AR_ACK);
		wr(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_CONTROL, 8'hc4);
		wait_ev(`ST_DR_ACK);
		rc(`OFF_DATA, 32'h1d);
		wr(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_CONTROL, 8'h84);
		wait_ev(`ST_DR_NACK);
		rc(`OFF_DATA, 32'h1d);
		wr(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_CONTROL, 8'ha4);
		wait_ev(`ST_RSTART);
		chk("clock held", 32'h1, {31'h0, scl_oe});
		wr(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_DATA, 8'h2b);
		wr(`OFF_CONTROL, 8'h84);
		wait_ev(`ST_AR_NACK);
		wr(`OFF_IRQ_STATUS, 8'h01);
		wr(`OFF_CONTROL, 8'h94);
		for (n = 0; n < 5000 && (scl_oe || sda_oe); n++)
			@(posedge aclk);
		chk("lines", 32'h0, {30'h0, scl_oe, sda_oe});
		repeat (700) @(posedge aclk);
		rc(`OFF_CONTROL, 32'h0, 32'h10);
		rc(`OFF_STATUS, 32'hf8);
		complete_run;
	end
endmodule // test_twowire_master_receiver
`default_nettype wire

//--- verif/twm_checker_properties.sv
// Bus and line checker for the two-wire master receiver
`timescale 1ns/10ps
`default_nettype none
module twm_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus handshakes
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	// Line enables
	input wire logic        scl_oe,
	input wire logic        sda_oe
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_B_ANSWER: assert property (awvalid && awready && wvalid && wready
		|=> ##1 bvalid) else $error("write answer late");
	AST_B_STAND: assert property (bvalid && !bready |=> bvalid)
		else $error("write answer dropped");
	AST_R_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	AST_R_STAND: assert property (rvalid && !rready
		|=> rvalid && $stable(rdata)) else $error("read answer moved");
	AST_AR_HOLD: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_START_SEQ: assert property (
		$rose(sda_oe) && !scl_oe |-> sda_oe throughout (##[1:1000] scl_oe))
		else $error("start condition broken");
	AST_STOP_IDLE: assert property (
		$fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe) [*8])
		else $error("bus not idle after stop");
endmodule // twm_checker

bind twowire_master_receiver twm_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready),
	.rdata(rdata), .scl_oe(scl_oe), .sda_oe(sda_oe)
);
`default_nettype wire
